// >>> hdl/hwp_consts.svh
// Constants for the host word-pair bus port: widths, reset values and pin packing.
`ifndef HWP_CONSTS_SVH
`define HWP_CONSTS_SVH

// Host address pins run from A1 up to this bit; A0 does not exist on a 16-bit bus.
`define HWP_ADDR_MSB 7
// Position of the word-half select line within the host address.
`define HWP_A1_BIT 1
// Lowest address bit of the doubleword index.
`define HWP_A2_BIT 2
// Host half-word and internal word widths.
`define HWP_HALF_W 16
`define HWP_WORD_W 32
// Number of interrupt sources that are gated onto the interrupt pin.
`define HWP_IRQ_W 8

// Packed pin vector: strobes on top, then mode selects, address and data.
`define HWP_PIN_W 28
`define HWP_PIN_CS 27
`define HWP_PIN_RD 26
`define HWP_PIN_WR 25
`define HWP_PIN_FIFO 24
`define HWP_PIN_END 23
`define HWP_PIN_ADDR_HI 22
`define HWP_PIN_ADDR_LO 16
`define HWP_PIN_DATA_HI 15

// Reset values: strobes read as deasserted, everything else as zero.
`define HWP_PIN_RST 28'hE000000
`define HWP_HALF_RST 16'h0000
`define HWP_WORD_RST 32'h00000000
`define HWP_IDX_RST 6'h00

`endif

// >>> hdl/hwp_pkg.sv
// Types and byte-order helpers shared by the host word-pair bus port modules.
package hwp_pkg;

    typedef logic [15:0] hwp_half_t;
    typedef logic [31:0] hwp_word_t;

    // Read-side sequencing of one host read strobe.
    typedef enum logic [1:0] {
        HWP_ST_IDLE = 2'b00,
        HWP_ST_FETCH = 2'b01,
        HWP_ST_DRIVE = 2'b10
    } hwp_state_t;

    // Reverses the four bytes of a word when big is set; the same swap maps both directions.
    function automatic hwp_word_t hwp_swap(input hwp_word_t w, input logic big);
        hwp_word_t r;
        r = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
        return r;
    endfunction : hwp_swap

    // Picks the host-visible half of an internal word for a given A1 and order.
    function automatic hwp_half_t hwp_half(input hwp_word_t w, input logic a1, input logic big);
        hwp_word_t h;
        h = hwp_swap(w, big);
        return a1 ? h[31:16] : h[15:0];
    endfunction : hwp_half

endpackage : hwp_pkg

// >>> hdl/hwp_pair_if.sv
// Carrier between the bus port top and its word-pair tracker.
interface hwp_pair_if;
    import hwp_pkg::*;

    logic wr_ev;
    logic rd_ev;
    logic a1;
    logic wr_commit;
    logic wr_drop;
    logic rd_fetch;
    logic rd_repeat;

    // The top reports host half cycles; the tracker classifies them.
    modport port (output wr_ev, output rd_ev, output a1,
                  input wr_commit, input wr_drop, input rd_fetch, input rd_repeat);
    modport tracker (input wr_ev, input rd_ev, input a1,
                     output wr_commit, output wr_drop, output rd_fetch, output rd_repeat);
endinterface : hwp_pair_if

// >>> hdl/hwp_pair.sv
// Word-pair tracker: decides which host half cycles open, close or spoil a pair.
module hwp_pair
    import hwp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Half-cycle events and their classification
    hwp_pair_if.tracker pif
);

    logic wr_pend_q;
    logic wr_half_q;
    logic rd_pend_q;
    logic rd_half_q;

    // Write pairing; reset empties the holding state so a new pair starts.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend_q <= 1'b0; // [R19]
            wr_half_q <= 1'b0;
        end
        else if (pif.wr_ev)
        begin
            // The second write closes the pair whether it matches or not.
            wr_pend_q <= !wr_pend_q; // [R05] [R06]
            wr_half_q <= pif.a1;
        end
    end

    // Read pairing; a repeated half drops tracking so the next read starts fresh.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_pend_q <= 1'b0; // [R19]
            rd_half_q <= 1'b0;
        end
        else if (pif.rd_ev)
        begin
            rd_pend_q <= !rd_pend_q; // [R08] [R09]
            rd_half_q <= pif.a1;
        end
    end

    // Classification is combinational so the top can act in the event cycle.
    always_comb
    begin
        pif.wr_commit = pif.wr_ev && wr_pend_q && (pif.a1 != wr_half_q); // [R05] [R07]
        pif.wr_drop = pif.wr_ev && wr_pend_q && (pif.a1 == wr_half_q); // [R06]
        pif.rd_fetch = pif.rd_ev && !rd_pend_q; // [R08]
        pif.rd_repeat = pif.rd_ev && rd_pend_q && (pif.a1 == rd_half_q); // [R09]
    end

endmodule : hwp_pair

// >>> hdl/hwp_port.sv
// Host word-pair bus port: 16-bit asynchronous host bus to 32-bit internal transfers.
// Function
// [R01] Host data is 16 bits; each 32-bit transfer takes two host half cycles.
// [R02] Host keeps the two halves atomic, nothing else in between.
// [R03] Host holds address and controls equal across halves, except A1.
// [R04] Host writes both halves within one doubleword, A2 and up unchanged.
// [R05] Write halves are accepted low first or high first.
// [R06] A second write to the same half discards the transfer.
// [R07] One internal 32-bit write follows only once both halves arrived.
// [R08] A 32-bit read is two reads of opposite halves in either order.
// [R09] A repeated same-half read clears read tracking; next read starts a pair.
// [R10] Host treats a repeated-half read value as invalid and re-reads.
// [R11] A lone 16-bit read returns valid data without the companion half.
// [R12] FIFO select high sends writes to transmit FIFO, reads from receive FIFO.
// [R13] Full address decoding is the default mapping mode.
// [R14] Byte order is chosen per access from the endian select input.
// [R15] Interrupt sources are observable, maskable, and enabled ones drive the pin.
// [R16] Endian select low is little endian, high is big endian.
// [R17] Internal words are little endian; bytes reorder by endian select and A1.
// [R18] After reset, host writes are ignored until one read has completed.
// [R19] Reset clears write holding and read tracking.
`include "hwp_consts.svh"

module hwp_port
    import hwp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Host bus pins
    input wire logic host_cs_b,
    input wire logic host_rd_b,
    input wire logic host_wr_b,
    input wire logic [`HWP_ADDR_MSB:`HWP_A1_BIT] host_addr,
    input wire logic [`HWP_HALF_W-1:0] host_data_in,
    output logic [`HWP_HALF_W-1:0] host_data_out,
    output logic host_data_oe_b,
    input wire logic host_fifo_sel,
    input wire logic host_end_sel,
    output logic host_irq,
    // Internal register path
    output logic [`HWP_ADDR_MSB:`HWP_A2_BIT] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [`HWP_WORD_W-1:0] reg_wdata,
    input wire logic [`HWP_WORD_W-1:0] reg_rdata,
    // Host MAC data FIFOs
    output logic tx_push,
    output logic [`HWP_WORD_W-1:0] tx_data,
    output logic rx_pop,
    input wire logic [`HWP_WORD_W-1:0] rx_data,
    // Interrupt sources and their enables
    input wire logic [`HWP_IRQ_W-1:0] irq_status,
    input wire logic [`HWP_IRQ_W-1:0] irq_enable
);

    // Pin synchroniser stages.
    logic [`HWP_PIN_W-1:0] pin_meta_q, pin_q;

    // Strobe history and write capture.
    logic rd_act_q, wr_act_q, armed_q, seen_read_q;
    logic wfifo_cap_q, wend_cap_q;
    logic [`HWP_ADDR_MSB:`HWP_A1_BIT] waddr_cap_q;
    hwp_half_t wdata_cap_q;
    hwp_word_t hold_q, merged;

    // Read context.
    hwp_state_t state_q;
    logic rd_a1_q, rd_end_sel_q, rd_fifo_q;
    hwp_word_t rword_q;

    // Output flops.
    logic data_oe_b_q, irq_q, reg_wr_q, reg_rd_q, tx_push_q, rx_pop_q;
    logic [`HWP_ADDR_MSB:`HWP_A2_BIT] reg_addr_q;
    hwp_half_t data_out_q;
    hwp_word_t reg_wdata_q, tx_data_q;

    hwp_pair_if pair_if ();

    // Every host pin is asynchronous to clk_sys, so all pass two flops first.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta_q <= `HWP_PIN_RST;
            pin_q <= `HWP_PIN_RST;
        end
        else
        begin
            pin_meta_q <= {host_cs_b, host_rd_b, host_wr_b, host_fifo_sel, host_end_sel,
                           host_addr, host_data_in};
            pin_q <= pin_meta_q;
        end
    end

    // Unpack the second stage only; nothing looks at the first.
    wire logic s_cs_b = pin_q[`HWP_PIN_CS];
    wire logic s_rd_b = pin_q[`HWP_PIN_RD];
    wire logic s_wr_b = pin_q[`HWP_PIN_WR];
    wire logic s_fifo = pin_q[`HWP_PIN_FIFO];
    wire logic s_end = pin_q[`HWP_PIN_END];
    wire logic [`HWP_ADDR_MSB:`HWP_A1_BIT] s_addr = pin_q[`HWP_PIN_ADDR_HI:`HWP_PIN_ADDR_LO];
    wire logic [`HWP_HALF_W-1:0] s_data = pin_q[`HWP_PIN_DATA_HI:0];

    // A cycle is either chip select or strobe controlled; both must be low.
    wire logic rd_act = !s_cs_b && !s_rd_b;
    wire logic wr_act = !s_cs_b && !s_wr_b;
    wire logic rd_go = rd_act && !rd_act_q && armed_q;
    wire logic rd_end = !rd_act && rd_act_q;
    wire logic wr_end = !wr_act && wr_act_q;

    // Strobe history; arming needs an idle read strobe, which pin_q shows from reset, so a read cut by reset is taken as a new read.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            armed_q <= 1'b0;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            armed_q <= armed_q || !rd_act;
        end
    end

    // While the write strobe is low, keep the latest data and controls for the trailing edge.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdata_cap_q <= `HWP_HALF_RST;
            waddr_cap_q <= {`HWP_IDX_RST, 1'b0};
            wfifo_cap_q <= 1'b0;
            wend_cap_q <= 1'b0;
        end
        else if (wr_act)
        begin
            wdata_cap_q <= s_data;
            waddr_cap_q <= s_addr;
            wfifo_cap_q <= s_fifo;
            wend_cap_q <= s_end;
        end
    end

    // Writes before the first completed read after reset never reach the tracker.
    wire logic wr_ev = wr_end && seen_read_q; // [R18]

    // Reads and writes cannot overlap on a legal bus, so the read side wins A1.
    assign pair_if.wr_ev = wr_ev;
    assign pair_if.rd_ev = rd_go;
    assign pair_if.a1 = rd_go ? s_addr[`HWP_A1_BIT] : waddr_cap_q[`HWP_A1_BIT];

    hwp_pair u_pair (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pif(pair_if.tracker)
    );

    // Place the incoming half into its host-view lane selected by A1.
    always_comb
    begin
        merged = hold_q;
        if (waddr_cap_q[`HWP_A1_BIT])
        begin
            merged[31:16] = wdata_cap_q; // [R17]
        end
        else
        begin
            merged[15:0] = wdata_cap_q; // [R17]
        end
    end

    // Host-view holding word for the pending write half.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_q <= `HWP_WORD_RST; // [R19]
        end
        else if (wr_ev)
        begin
            hold_q <= merged;
        end
    end

    // A completed read cycle opens the write path for the rest of operation.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            seen_read_q <= 1'b0; // [R18]
        end
        else if (rd_end && armed_q)
        begin
            seen_read_q <= 1'b1; // [R18]
        end
    end

    // Read sequencing: fetch a whole word on the first half, then drive halves.
    // Fetching on the first half is what lets a lone 16-bit read return good data.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= HWP_ST_IDLE;
            rd_a1_q <= 1'b0;
            rd_end_sel_q <= 1'b0;
            rd_fifo_q <= 1'b0;
            rword_q <= `HWP_WORD_RST;
        end
        else
        begin
            case (state_q)
                HWP_ST_IDLE:
                begin
                    if (rd_go)
                    begin
                        rd_a1_q <= s_addr[`HWP_A1_BIT];
                        rd_end_sel_q <= s_end; // [R14] [R16]
                        rd_fifo_q <= s_fifo;
                        // A repeated half serves the stale word; software re-reads.
                        state_q <= pair_if.rd_fetch ? HWP_ST_FETCH : HWP_ST_DRIVE; // [R09] [R11]
                    end
                end
                HWP_ST_FETCH:
                begin
                    rword_q <= rd_fifo_q ? rx_data : reg_rdata; // [R12] [R13]
                    state_q <= rd_end ? HWP_ST_IDLE : HWP_ST_DRIVE;
                end
                HWP_ST_DRIVE:
                begin
                    state_q <= rd_end ? HWP_ST_IDLE : HWP_ST_DRIVE;
                end
                default:
                begin
                    state_q <= HWP_ST_IDLE;
                end
            endcase
        end
    end

    // Host data pins: driven only while the read strobe is seen active.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_out_q <= `HWP_HALF_RST;
            data_oe_b_q <= 1'b1;
        end
        else if (state_q == HWP_ST_DRIVE && !rd_end)
        begin
            data_out_q <= hwp_half(rword_q, rd_a1_q, rd_end_sel_q); // [R14] [R16] [R17]
            data_oe_b_q <= 1'b0;
        end
        else
        begin
            data_oe_b_q <= 1'b1;
        end
    end

    // Internal requests: one-cycle pulses, with address and data held after.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_addr_q <= `HWP_IDX_RST;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            reg_wdata_q <= `HWP_WORD_RST;
            tx_push_q <= 1'b0;
            tx_data_q <= `HWP_WORD_RST;
            rx_pop_q <= 1'b0;
        end
        else
        begin
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            tx_push_q <= 1'b0;
            rx_pop_q <= 1'b0;
            if (rd_go && pair_if.rd_fetch && state_q == HWP_ST_IDLE)
            begin
                // FIFO select overrides the address entirely.
                if (s_fifo)
                begin
                    rx_pop_q <= 1'b1; // [R12]
                end
                else
                begin
                    reg_rd_q <= 1'b1; // [R13]
                    reg_addr_q <= s_addr[`HWP_ADDR_MSB:`HWP_A2_BIT];
                end
            end
            else if (pair_if.wr_commit)
            begin
                if (wfifo_cap_q)
                begin
                    tx_push_q <= 1'b1; // [R12] [R07]
                    tx_data_q <= hwp_swap(merged, wend_cap_q); // [R14] [R17]
                end
                else
                begin
                    reg_wr_q <= 1'b1; // [R07] [R13] [R01]
                    reg_addr_q <= waddr_cap_q[`HWP_ADDR_MSB:`HWP_A2_BIT];
                    reg_wdata_q <= hwp_swap(merged, wend_cap_q); // [R14] [R17]
                end
            end
        end
    end

    // Sources are observed upstream and masked here by irq_enable; only enabled ones reach the pin.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_status & irq_enable); // [R15]
        end
    end

    // Every output comes straight from a flop.
    assign host_data_out = data_out_q;
    assign host_data_oe_b = data_oe_b_q;
    assign host_irq = irq_q;
    assign reg_addr = reg_addr_q;
    assign reg_wr = reg_wr_q;
    assign reg_rd = reg_rd_q;
    assign reg_wdata = reg_wdata_q;
    assign tx_push = tx_push_q;
    assign tx_data = tx_data_q;
    assign rx_pop = rx_pop_q;

endmodule : hwp_port

// >>> dv/hwp_port_props.sv
// Concurrent checks on the pins of the host word-pair bus port.
module hwp_port_props
    import hwp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Host bus pins
    input wire logic host_cs_b,
    input wire logic host_rd_b,
    input wire logic host_wr_b,
    input wire logic [7:1] host_addr,
    input wire logic [15:0] host_data_in,
    input wire logic [15:0] host_data_out,
    input wire logic host_data_oe_b,
    input wire logic host_fifo_sel,
    input wire logic host_end_sel,
    input wire logic host_irq,
    // Internal side
    input wire logic [7:2] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic tx_push,
    input wire logic [31:0] tx_data,
    input wire logic rx_pop,
    input wire logic [31:0] rx_data,
    input wire logic [7:0] irq_status,
    input wire logic [7:0] irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // The pin is the masked sources, registered once.
    property p_irq_follow;
        1'b1 |=> host_irq == $past(|(irq_status & irq_enable));
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq pin mismatch");
    property p_wr_pulse;
        reg_wr |=> !reg_wr && !tx_push;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("register write not single");
    property p_push_pulse;
        tx_push |-> !reg_wr ##1 !tx_push;
    endproperty
    a_push_pulse: assert property (p_push_pulse) else $error("fifo push not single");
    property p_fetch_once;
        (reg_rd || rx_pop) |=> !(reg_rd || rx_pop);
    endproperty
    a_fetch_once: assert property (p_fetch_once) else $error("fetch not single");
    // A fetched word reaches the pins two cycles after the fetch.
    property p_fetch_drive;
        (reg_rd || rx_pop) |-> ##2 !host_data_oe_b;
    endproperty
    a_fetch_drive: assert property (p_fetch_drive) else $error("fetched half not driven");
    property p_idle_release;
        host_rd_b [*6] |-> host_data_oe_b;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("bus driven while idle");
    property p_data_hold;
        !host_data_oe_b && $past(!host_data_oe_b) |-> $stable(host_data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved");
    property p_commit_after_strobe;
        (reg_wr || tx_push) |-> $past(host_wr_b) && !reg_rd && !rx_pop;
    endproperty
    a_commit_after_strobe: assert property (p_commit_after_strobe) else $error("early commit");
    c_reg_wr: cover property (reg_wr);
    c_tx_push: cover property (tx_push);
    c_rx_pop: cover property (rx_pop);
    c_irq: cover property (host_irq);
endmodule : hwp_port_props

bind hwp_port hwp_port_props u_props (.clk_sys, .rst_b, .host_cs_b, .host_rd_b, .host_wr_b,
    .host_addr, .host_data_in, .host_data_out, .host_data_oe_b, .host_fifo_sel, .host_end_sel,
    .host_irq, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_push, .tx_data,
    .rx_pop, .rx_data, .irq_status, .irq_enable);

// >>> dv/hwp_far_model.sv
// Model of the internal registers and receive FIFO behind the bus port.
module hwp_far_model
    import hwp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Register side
    input wire logic [7:2] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output hwp_word_t reg_rdata,
    // Receive FIFO side
    input wire logic rx_pop,
    output hwp_word_t rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    hwp_word_t mem_q [64];
    logic [15:0] rx_cnt_q;

    // Register storage; a write lands only on the commit pulse.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            for (int i = 0; i < 64; i++) mem_q[i] <= {10'h1F8, i[5:0], 10'h2D4, i[5:0]};
        else if (reg_wr)
            mem_q[reg_addr] <= reg_wdata;
    end

    // The port takes the answer in the cycle its request pulse is high; at any other
    // time the lines show the inverse, so a late or early sample never matches.
    always_comb
    begin
        reg_rdata = reg_rd ? mem_q[reg_addr] : ~mem_q[reg_addr];
        rx_data = rx_pop ? {16'h5EED, rx_cnt_q} : ~{16'h5EED, rx_cnt_q};
    end

    // Receive words count up from zero, one per pop.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rx_cnt_q <= 16'h0000;
        else
            rx_cnt_q <= rx_cnt_q + {15'h0000, rx_pop};
    end
endmodule : hwp_far_model

// >>> dv/testbench.sv
// Self-checking bench for the host word-pair bus port.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hwp_pkg::*;
    logic clk_sys = 0, rst_b = 0, host_cs_b = 1, host_rd_b = 1, host_wr_b = 1;
    logic host_fifo_sel = 0, host_end_sel = 0, host_irq, host_data_oe_b;
    logic [7:1] host_addr = 0;
    logic [15:0] host_data_in = 0, host_data_out;
    logic [7:0] irq_status = 0, irq_enable = 0;
    logic [7:2] reg_addr, last_a;
    logic reg_wr, reg_rd, tx_push, rx_pop;
    hwp_word_t reg_wdata, reg_rdata, tx_data, rx_data, last_w;
    int err_count = 0, comparisons = 0, wr_n = 0, push_n = 0, fetch_n = 0;

    hwp_port dut_u (.clk_sys, .rst_b, .host_cs_b, .host_rd_b, .host_wr_b, .host_addr,
        .host_data_in, .host_data_out, .host_data_oe_b, .host_fifo_sel, .host_end_sel,
        .host_irq, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tx_push, .tx_data,
        .rx_pop, .rx_data, .irq_status, .irq_enable);
    hwp_far_model far_u (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .rx_pop, .rx_data);

    always #4 clk_sys = ~clk_sys;

    // Counts internal transfers; values are read before the edge updates them.
    always @(posedge clk_sys)
    begin
        if (reg_wr) begin wr_n++; last_w = reg_wdata; last_a = reg_addr; end
        if (tx_push) begin push_n++; last_w = tx_data; end
        if (reg_rd || rx_pop) fetch_n++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    function automatic hwp_word_t init_w(input logic [5:0] i);
        return {10'h1F8, i, 10'h2D4, i};
    endfunction : init_w

    function automatic hwp_word_t bswap(input hwp_word_t w, input logic e);
        return e ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction : bswap

    // One host write half; strobe low five cycles, then idle six.
    task automatic hw(input logic [7:1] a, input hwp_half_t d, input logic f, input logic e);
        @(posedge clk_sys);
        host_cs_b <= 0; host_wr_b <= 0; host_addr <= a; host_data_in <= d;
        host_fifo_sel <= f; host_end_sel <= e;
        tick(5);
        host_cs_b <= 1; host_wr_b <= 1;
        tick(6);
    endtask : hw

    // One host read half; holds the strobe until the port drives, bounded.
    task automatic hr(input logic [7:1] a, input logic f, input logic e, output hwp_half_t d);
        int i;
        @(posedge clk_sys);
        host_cs_b <= 0; host_rd_b <= 0; host_addr <= a; host_fifo_sel <= f;
        host_end_sel <= e;
        i = 0;
        while (host_data_oe_b !== 1'b0 && i < 20) begin @(posedge clk_sys); i++; end
        if (i == 20) begin err_count++; tally_and_finish(); end
        tick(1);
        d = host_data_out;
        host_cs_b <= 1; host_rd_b <= 1;
        tick(6);
    endtask : hr

    task automatic wpair(input logic [5:0] dw, input logic a1, input hwp_half_t h0,
                         input hwp_half_t h1, input logic f, input logic e);
        int n, p;
        hwp_word_t w;
        n = wr_n;
        p = push_n;
        w = bswap({h1, h0}, e);
        hw({dw, a1}, a1 ? h1 : h0, f, e);
        chk(wr_n + push_n, n + p);
        hw({dw, ~a1}, a1 ? h0 : h1, f, e);
        chk(push_n, p + f);
        chk(wr_n, n + !f);
        chk(last_w, w);
        if (!f) chk(last_a, dw);
    endtask : wpair

    task automatic rpair(input logic [5:0] dw, input logic a1, input logic f, input logic e,
                         input hwp_word_t iw);
        int n;
        hwp_word_t hv;
        hwp_half_t h;
        n = fetch_n;
        hv = bswap(iw, e);
        hr({dw, a1}, f, e, h);
        chk(h, a1 ? hv[31:16] : hv[15:0]);
        hr({dw, ~a1}, f, e, h);
        chk(h, a1 ? hv[15:0] : hv[31:16]);
        chk(fetch_n, n + 1);
    endtask : rpair

    task automatic s_after_reset;
        hwp_half_t h;
        hwp_word_t w;
        w = init_w(6'h05);
        hw(7'h0A, 16'hAAAA, 0, 0);
        hw(7'h0B, 16'hBBBB, 0, 0);
        chk(wr_n, 0);
        hr(7'h0A, 0, 0, h);
        chk(h, w[15:0]);
        chk(fetch_n, 1);
        hr(7'h0B, 0, 0, h);
        chk(h, w[31:16]);
        wpair(6'h05, 0, 16'h0102, 16'h0304, 0, 0);
    endtask : s_after_reset

    task automatic s_pairs;
        int n;
        wpair(6'h03, 0, 16'h1122, 16'h3344, 0, 0);
        rpair(6'h03, 1, 0, 1, 32'h33441122);
        wpair(6'h03, 1, 16'h5566, 16'h7788, 0, 1);
        rpair(6'h03, 0, 0, 0, 32'h66558877);
        n = wr_n;
        hw(7'h12, 16'hDEAD, 0, 0);
        hw(7'h12, 16'hBEEF, 0, 0);
        chk(wr_n, n);
        wpair(6'h09, 0, 16'hCAFE, 16'hF00D, 0, 0);
        rpair(6'h09, 0, 0, 0, 32'hF00DCAFE);
    endtask : s_pairs

    task automatic s_repeat;
        int n;
        hwp_half_t h;
        n = fetch_n;
        hr(7'h0E, 0, 0, h);
        hr(7'h0E, 0, 0, h);
        chk(fetch_n, n + 1);
        rpair(6'h07, 1, 0, 0, init_w(6'h07));
    endtask : s_repeat

    task automatic s_fifo_irq;
        wpair(6'h3F, 0, 16'hA5A5, 16'h5A5A, 1, 0);
        wpair(6'h01, 1, 16'h1357, 16'h2468, 1, 1);
        rpair(6'h2A, 0, 1, 0, 32'h5EED0000);
        rpair(6'h11, 1, 1, 1, 32'h5EED0001);
        for (int i = 0; i < 8; i++)
        begin
            irq_status <= 8'h01 << i;
            irq_enable <= (i % 2) ? (8'h01 << i) : ~(8'h01 << i);
            tick(3);
            chk(host_irq, i % 2);
        end
    endtask : s_fifo_irq

    initial
    begin
        tick(16);
        rst_b <= 1;
        tick(4);
        s_after_reset();
        s_pairs();
        s_repeat();
        s_fifo_irq();
        tally_and_finish();
    end
endmodule : testbench
